// ### decoder_regs_pkg.sv
// Register map, field positions, reset values and pixel path constants
package decoder_regs_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  STATUS2_OFS = 8'h1F;
   localparam logic [7:0]  AIC5_OFS    = 8'h23;
   localparam logic [7:0]  GAIN3_OFS   = 8'h24;
   localparam logic [7:0]  GAIN4_OFS   = 8'h25;
   localparam logic [7:0]  CDS_OFS     = 8'h29;

   // ****************************************
   // Second status byte fields
   // ****************************************
   localparam int unsigned ST_INTERLACE_DETECTED_BIT   = 7;
   localparam int unsigned ST_HVUL_BIT   = 6;
   localparam int unsigned ST_FIELD_BIT  = 5;
   localparam int unsigned ST_UNUSED_BIT = 4;
   localparam int unsigned ST_STRIPE_BURST_FOUR_LINE_BIT  = 3;
   localparam int unsigned ST_STRIPE_BIT = 2;
   localparam int unsigned ST_COPY_PROTECT_SEEN_BIT  = 1;
   localparam int unsigned ST_CAPTURE_READY_BIT  = 0;

   // ****************************************
   // Analog input control five fields
   // ****************************************
   localparam int unsigned AOUT_HI_BIT   = 7;
   localparam int unsigned ADC_DRV_BIT   = 6;
   localparam int unsigned ADC_CLK_BIT   = 5;
   localparam int unsigned CLAMP_REF_BIT = 4;
   localparam int unsigned SRC_SW_BIT    = 2;
   localparam int unsigned CH4_MSB_BIT   = 1;
   localparam int unsigned CH3_MSB_BIT   = 0;
   localparam logic [7:0]  AIC5_MASK     = 8'hF7;

   // ****************************************
   // Component delay and pixel mix fields
   // ****************************************
   localparam int unsigned MIX_EN_BIT    = 7;
   localparam int unsigned MIX_POL_BIT   = 6;
   localparam int unsigned MIX_DLY_LSB   = 4;
   localparam int unsigned PEAK_BIT      = 3;
   localparam int unsigned CPATH_LSB     = 0;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0]  AIC5_RST      = 8'h00;
   localparam logic [7:0]  GAIN3_RST     = 8'h00;
   localparam logic [7:0]  GAIN4_RST     = 8'h00;
   localparam logic [7:0]  CDS_RST       = 8'h00;

   // ****************************************
   // Pixel path timing, in pixel clocks
   // ****************************************
   localparam int unsigned DELAY_DEPTH   = 36;
   localparam logic [6:0]  PATH_BASE_TAP = 7'h15;
   localparam logic [6:0]  FSW_LAT_ADJ   = 7'h02;

endpackage : decoder_regs_pkg

// ### decoder_status_component_ctrl.sv
// Status byte two and component input control registers with pixel mix path
//
// Behaviour
// - Status bit 7 shows interlaced source
// - Status bit 6 high when loops unlocked
// - Status bit 5: 0 is 50 Hz, 1 60 Hz
// - Bits 3..1 show stripe bursts, copy protection
// - Bit 0 only when all locked, ready
// - Status byte read-only, host writes ignored
// - Port drive bit 0 floats raw ADC port
// - Clock select: internal line-locked or external pin
// - Reference pull or clamp by mode bit
// - Enabled switch input edges reset gain loop
// - Channel 3 gain: MSB plus low register
// - Channel 4 gain: MSB plus low register
// - Mix enable selects source per pixel
// - Polarity bit inverts mix input mapping
// - Without mixing, polarity bit selects source statically
// - Mix input delay 0, +1, -2, -1 pixel
// - Optional component luma peaking
// - Component shift in steps of four pixels
`timescale 1ns/100ps
module decoder_status_component_ctrl #(
   parameter int unsigned PIX_W = 16,
   parameter int unsigned ADC_W = 9
) (
   input  wire logic             I_CLK,
   input  wire logic             I_RSTN,
   input  wire logic             I_REG_WR,
   input  wire logic             I_REG_RD,
   input  wire logic [7:0]       I_REG_ADDR,
   input  wire logic [7:0]       I_REG_WDATA,
   output logic      [7:0]       O_REG_RDATA,
   output logic                  O_REG_RDVALID,
   input  wire logic             I_INTERLACE_DETECTED,
   input  wire logic             I_HV_LOOPS_UNLOCKED,
   input  wire logic             I_FIELD_RATE_ID,
   input  wire logic             I_STRIPE_BURST_FOUR_LINE,
   input  wire logic             I_STRIPE_BURST_ANY,
   input  wire logic             I_COPY_PROTECT_SEEN,
   input  wire logic             I_ALL_LOOPS_LOCKED,
   input  wire logic             I_CAPTURE_READY,
   input  wire logic [ADC_W-1:0] I_ADC_RAW,
   output logic      [ADC_W-1:0] O_ADC_PORT_DATA,
   output logic                  O_ADC_PORT_OE_N,
   output logic                  O_ADC_CLOCK_EXTERNAL_SEL,
   output logic                  O_ANALOG_OUT_SEL_HI,
   input  wire logic             I_CLAMP_MODE_BIT,
   output logic                  O_REF_PULL_EN,
   output logic                  O_CLAMP_APPLY,
   input  wire logic             I_SOURCE_SWITCH_IN,
   output logic                  O_GAIN_LOOP_RESET,
   output logic      [8:0]       O_CHAN3_GAIN,
   output logic      [8:0]       O_CHAN4_GAIN,
   input  wire logic             I_PIXEL_MIX_IN,
   input  wire logic [PIX_W-1:0] I_COMPOSITE_PIX,
   input  wire logic [PIX_W-1:0] I_COMPONENT_PIX,
   output logic      [PIX_W-1:0] O_PIX,
   output logic                  O_PIX_IS_COMPONENT
);

   localparam int unsigned SEL_W = 6;

   if (PIX_W < 8 || ADC_W < 1) begin : g_bad_cfg
      $error("decoder_status_component_ctrl: PIX_W must be at least 8");
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   // ****************************************
   // Register file
   // ****************************************
   logic [7:0] status_r;
   logic [7:0] aic5_r;
   logic [7:0] gain3_r;
   logic [7:0] gain4_r;
   logic [7:0] cds_r;
   logic       capture_ready_w;

   assign capture_ready_w = I_CAPTURE_READY & I_ALL_LOOPS_LOCKED & ~I_HV_LOOPS_UNLOCKED;

   // Status is re-sampled every clock so a read never shows stale flags
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         status_r <= 8'h00;
      end else begin
         status_r[decoder_regs_pkg::ST_INTERLACE_DETECTED_BIT]   <= I_INTERLACE_DETECTED;
         status_r[decoder_regs_pkg::ST_HVUL_BIT]   <= I_HV_LOOPS_UNLOCKED;
         status_r[decoder_regs_pkg::ST_FIELD_BIT]  <= I_FIELD_RATE_ID;
         status_r[decoder_regs_pkg::ST_UNUSED_BIT] <= 1'b0;
         status_r[decoder_regs_pkg::ST_STRIPE_BURST_FOUR_LINE_BIT]  <= I_STRIPE_BURST_FOUR_LINE;
         status_r[decoder_regs_pkg::ST_STRIPE_BIT] <= I_STRIPE_BURST_ANY;
         status_r[decoder_regs_pkg::ST_COPY_PROTECT_SEEN_BIT]  <= I_COPY_PROTECT_SEEN;
         status_r[decoder_regs_pkg::ST_CAPTURE_READY_BIT]  <= capture_ready_w;
      end
   end

   // No case item for the status offset: writes there fall through
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         aic5_r  <= decoder_regs_pkg::AIC5_RST;
         gain3_r <= decoder_regs_pkg::GAIN3_RST;
         gain4_r <= decoder_regs_pkg::GAIN4_RST;
         cds_r   <= decoder_regs_pkg::CDS_RST;
      end else if (I_REG_WR) begin
         case (I_REG_ADDR)
            decoder_regs_pkg::AIC5_OFS: begin
               aic5_r <= I_REG_WDATA & decoder_regs_pkg::AIC5_MASK;
            end
            decoder_regs_pkg::GAIN3_OFS: begin
               gain3_r <= I_REG_WDATA;
            end
            decoder_regs_pkg::GAIN4_OFS: begin
               gain4_r <= I_REG_WDATA;
            end
            decoder_regs_pkg::CDS_OFS: begin
               cds_r <= I_REG_WDATA;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_REG_RDATA   <= 8'h00;
         O_REG_RDVALID <= 1'b0;
      end else begin
         O_REG_RDVALID <= I_REG_RD;
         if (I_REG_RD) begin
            case (I_REG_ADDR)
               decoder_regs_pkg::STATUS2_OFS: O_REG_RDATA <= status_r;
               decoder_regs_pkg::AIC5_OFS:    O_REG_RDATA <= aic5_r;
               decoder_regs_pkg::GAIN3_OFS:   O_REG_RDATA <= gain3_r;
               decoder_regs_pkg::GAIN4_OFS:   O_REG_RDATA <= gain4_r;
               decoder_regs_pkg::CDS_OFS:     O_REG_RDATA <= cds_r;
               default:                       O_REG_RDATA <= 8'h00;
            endcase
         end
      end
   end

   // ****************************************
   // Analog front-end controls
   // ****************************************
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_ADC_PORT_DATA          <= '0;
         O_ADC_PORT_OE_N          <= 1'b1;
         O_ADC_CLOCK_EXTERNAL_SEL <= 1'b0;
         O_ANALOG_OUT_SEL_HI      <= 1'b0;
         O_REF_PULL_EN            <= 1'b0;
         O_CLAMP_APPLY            <= 1'b0;
         O_CHAN3_GAIN             <= 9'h000;
         O_CHAN4_GAIN             <= 9'h000;
      end else begin
         O_ADC_PORT_DATA          <= I_ADC_RAW;
         O_ADC_PORT_OE_N          <= ~aic5_r[decoder_regs_pkg::ADC_DRV_BIT];
         O_ADC_CLOCK_EXTERNAL_SEL <= aic5_r[decoder_regs_pkg::ADC_CLK_BIT];
         O_ANALOG_OUT_SEL_HI      <= aic5_r[decoder_regs_pkg::AOUT_HI_BIT];
         O_REF_PULL_EN            <= aic5_r[decoder_regs_pkg::CLAMP_REF_BIT];
         O_CLAMP_APPLY            <= ~aic5_r[decoder_regs_pkg::CLAMP_REF_BIT]
                                     & I_CLAMP_MODE_BIT;
         O_CHAN3_GAIN             <= {aic5_r[decoder_regs_pkg::CH3_MSB_BIT], gain3_r};
         O_CHAN4_GAIN             <= {aic5_r[decoder_regs_pkg::CH4_MSB_BIT], gain4_r};
      end
   end

   // ****************************************
   // Pin synchronisers: index 0 switch input, 1 mix input
   // ****************************************
   logic [1:0] pin_w;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] sync3_r;
   logic [1:0] stable_r;
   logic [1:0] change_w;

   assign pin_w = {I_PIXEL_MIX_IN, I_SOURCE_SWITCH_IN};

   for (genvar g = 0; g < 2; g++) begin : g_sync
      assign change_w[g] = (sync2_r[g] == sync3_r[g]) && (sync3_r[g] != stable_r[g]);
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
         if (!I_RSTN) begin
            sync1_r[g]  <= 1'b0;
            sync2_r[g]  <= 1'b0;
            sync3_r[g]  <= 1'b0;
            stable_r[g] <= 1'b0;
         end else begin
            sync1_r[g] <= pin_w[g];
            sync2_r[g] <= sync1_r[g];
            sync3_r[g] <= sync2_r[g];
            if (change_w[g]) begin
               stable_r[g] <= sync3_r[g];
            end
         end
      end
   end

   // Either slope counts; while disabled the pin is still tracked so that
   // enabling does not fire on a level that changed long ago
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_GAIN_LOOP_RESET <= 1'b0;
      end else begin
         O_GAIN_LOOP_RESET <= aic5_r[decoder_regs_pkg::SRC_SW_BIT] & change_w[0];
      end
   end

   // ****************************************
   // Component luma peaking
   // ****************************************
   logic [PIX_W-1:0]  comp_d0_r;
   logic [PIX_W-1:0]  comp_d1_r;
   logic [PIX_W-1:0]  comp_pk_r;
   logic [PIX_W-1:0]  composite_video_d0_r;
   logic [PIX_W-1:0]  composite_video_pk_r;
   logic signed [10:0] hp_w;
   logic signed [10:0] peak_w;
   logic [7:0]        peak_luma_w;
   logic              peak_en;

   assign peak_en = cds_r[decoder_regs_pkg::PEAK_BIT];
   // High-pass of the centre sample, one eighth added back: a cheap
   // three-tap boost that peaks at half the pixel rate
   assign hp_w = 11'(signed'({3'b000, comp_d0_r[PIX_W-1 -: 8]} <<< 1))
               - signed'({3'b000, I_COMPONENT_PIX[PIX_W-1 -: 8]})
               - signed'({3'b000, comp_d1_r[PIX_W-1 -: 8]});
   assign peak_w = signed'({3'b000, comp_d0_r[PIX_W-1 -: 8]}) + (hp_w >>> 3);
   assign peak_luma_w = (peak_w < 0) ? 8'h00 : (peak_w > 11'sh0FF) ? 8'hFF : peak_w[7:0];

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         comp_d0_r <= '0;
         comp_d1_r <= '0;
         comp_pk_r <= '0;
         composite_video_d0_r <= '0;
         composite_video_pk_r <= '0;
      end else begin
         comp_d0_r <= I_COMPONENT_PIX;
         comp_d1_r <= comp_d0_r;
         composite_video_d0_r <= I_COMPOSITE_PIX;
         composite_video_pk_r <= composite_video_d0_r;
         comp_pk_r <= comp_d0_r;
         if (peak_en) begin
            comp_pk_r[PIX_W-1 -: 8] <= peak_luma_w;
         end
      end
   end

   // ****************************************
   // Path alignment delays
   // ****************************************
   logic [6:0]       cpath_ofs_w;
   logic [6:0]       fsw_ofs_w;
   logic [6:0]       comp_tap_w;
   logic [6:0]       fsw_tap_w;
   logic [PIX_W-1:0] composite_video_al_w;
   logic [PIX_W-1:0] comp_al_w;
   logic             fsw_al_w;

   localparam int unsigned CPATH_MSB   = decoder_regs_pkg::CPATH_LSB + 2;
   localparam int unsigned MIX_DLY_MSB = decoder_regs_pkg::MIX_DLY_LSB + 1;

   // Shift code is a signed count of four-pixel steps
   assign cpath_ofs_w = {{2{cds_r[CPATH_MSB]}}, cds_r[CPATH_MSB:0], 2'b00};
   assign comp_tap_w  = decoder_regs_pkg::PATH_BASE_TAP + cpath_ofs_w;
   // Mix delay code is a signed 2-bit pixel count; the mix pin's
   // synchroniser latency is subtracted so that code 0 lands aligned
   assign fsw_ofs_w   = {{5{cds_r[MIX_DLY_MSB]}}, cds_r[MIX_DLY_MSB:decoder_regs_pkg::MIX_DLY_LSB]};
   assign fsw_tap_w   = comp_tap_w + fsw_ofs_w - decoder_regs_pkg::FSW_LAT_ADJ;

   pixel_delay_line #(.W(PIX_W), .DEPTH(decoder_regs_pkg::DELAY_DEPTH), .SEL_W(SEL_W)) u_composite_video_dly (
      .i_clk  (I_CLK),
      .i_rstn (I_RSTN),
      .i_din  (composite_video_pk_r),
      .i_sel  (decoder_regs_pkg::PATH_BASE_TAP[SEL_W-1:0]),
      .o_dout (composite_video_al_w)
   );

   pixel_delay_line #(.W(PIX_W), .DEPTH(decoder_regs_pkg::DELAY_DEPTH), .SEL_W(SEL_W)) u_comp_dly (
      .i_clk  (I_CLK),
      .i_rstn (I_RSTN),
      .i_din  (comp_pk_r),
      .i_sel  (comp_tap_w[SEL_W-1:0]),
      .o_dout (comp_al_w)
   );

   pixel_delay_line #(.W(1), .DEPTH(decoder_regs_pkg::DELAY_DEPTH), .SEL_W(SEL_W)) u_fsw_dly (
      .i_clk  (I_CLK),
      .i_rstn (I_RSTN),
      .i_din  (stable_r[1]),
      .i_sel  (fsw_tap_w[SEL_W-1:0]),
      .o_dout (fsw_al_w)
   );

   // ****************************************
   // Source selection
   // ****************************************
   logic mix_en;
   logic mix_pol;
   logic use_comp_w;

   assign mix_en  = cds_r[decoder_regs_pkg::MIX_EN_BIT];
   assign mix_pol = cds_r[decoder_regs_pkg::MIX_POL_BIT];
   // Mixing assumes the component source is locked to the composite one
   assign use_comp_w = mix_en ? (fsw_al_w ^ mix_pol) : mix_pol;

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_PIX              <= '0;
         O_PIX_IS_COMPONENT <= 1'b0;
      end else begin
         O_PIX              <= use_comp_w ? comp_al_w : composite_video_al_w;
         O_PIX_IS_COMPONENT <= use_comp_w;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_status_loop_flags: assert property (
      I_REG_RD && I_REG_ADDR == decoder_regs_pkg::STATUS2_OFS |=>
      O_REG_RDATA[7:5] == {$past(I_INTERLACE_DETECTED, 2), $past(I_HV_LOOPS_UNLOCKED, 2),
                           $past(I_FIELD_RATE_ID, 2)})
      else $error("status loop flags wrong");
   chk_status_stripe_flags: assert property (
      I_REG_RD && I_REG_ADDR == decoder_regs_pkg::STATUS2_OFS |=>
      O_REG_RDATA[3:1] == {$past(I_STRIPE_BURST_FOUR_LINE, 2), $past(I_STRIPE_BURST_ANY, 2),
                           $past(I_COPY_PROTECT_SEEN, 2)})
      else $error("status stripe flags wrong");
   chk_capture_ready_bit: assert property (
      I_REG_RD && I_REG_ADDR == decoder_regs_pkg::STATUS2_OFS |=>
      O_REG_RDATA[0] == ($past(I_CAPTURE_READY, 2) && $past(I_ALL_LOOPS_LOCKED, 2)
                         && !$past(I_HV_LOOPS_UNLOCKED, 2)))
      else $error("capture ready bit wrong");
   chk_status_bit4_zero: assert property (
      I_REG_RD && I_REG_ADDR == decoder_regs_pkg::STATUS2_OFS |=> O_REG_RDATA[4] == 1'b0)
      else $error("status bit 4 not zero");
   chk_status_write_ignored: assert property (
      I_REG_WR && I_REG_ADDR == decoder_regs_pkg::STATUS2_OFS |=>
      $stable(aic5_r) && $stable(gain3_r) && $stable(gain4_r) && $stable(cds_r))
      else $error("status write changed a register");
   chk_adc_port_enable: assert property (
      I_REG_WR && I_REG_ADDR == decoder_regs_pkg::AIC5_OFS ##1 !I_REG_WR |=>
      O_ADC_PORT_OE_N == !$past(I_REG_WDATA[decoder_regs_pkg::ADC_DRV_BIT], 2))
      else $error("ADC port drive not following control");
   chk_adc_clock_select: assert property (
      I_REG_WR && I_REG_ADDR == decoder_regs_pkg::AIC5_OFS ##1 !I_REG_WR |=>
      O_ADC_CLOCK_EXTERNAL_SEL == $past(I_REG_WDATA[decoder_regs_pkg::ADC_CLK_BIT], 2))
      else $error("ADC clock select not following control");
   chk_clamp_or_ref: assert property (
      O_CLAMP_APPLY |-> !O_REF_PULL_EN && $past(I_CLAMP_MODE_BIT))
      else $error("clamp applied with reference pull");
   chk_switch_reset_gate: assert property (
      O_GAIN_LOOP_RESET |-> $past(aic5_r[decoder_regs_pkg::SRC_SW_BIT])
                            && $past(stable_r[0]) != $past(sync3_r[0]))
      else $error("gain reset without enabled edge");
   chk_gain_words: assert property (
      O_CHAN3_GAIN == {$past(aic5_r[0]), $past(gain3_r)}
      && O_CHAN4_GAIN == {$past(aic5_r[1]), $past(gain4_r)})
      else $error("static gain word wrong");
   chk_static_select: assert property (
      !mix_en |=> O_PIX_IS_COMPONENT == $past(mix_pol))
      else $error("static source select wrong");
   chk_mix_polarity: assert property (
      mix_en |=> O_PIX_IS_COMPONENT == ($past(fsw_al_w) ^ $past(mix_pol)))
      else $error("pixel mix polarity wrong");
   chk_delay_taps: assert property (
      fsw_tap_w == 7'(comp_tap_w + fsw_ofs_w - 7'h02) && comp_tap_w >= 7'h05 && comp_tap_w <= 7'h21)
      else $error("delay tap out of range");
   chk_peak_bypass: assert property (
      !peak_en && $past(I_RSTN) |=> comp_pk_r == $past(I_COMPONENT_PIX, 2))
      else $error("peaking active while disabled");

endmodule : decoder_status_component_ctrl

// ### decoder_status_component_ctrl_tb.sv
// Self-checking bench for the status and component control register block
`timescale 1ns/100ps
module decoder_status_component_ctrl_tb;
   logic        clk, rstn, wr, rd, rdv, oe_n, ext, aout, refp, clamp, sw, grst, mix, isc, cm;
   logic [7:0]  addr, wdata, rdata, st, q;
   logic [8:0]  adc_o, g3, g4;
   logic [15:0] n, pix;
   logic [3:0]  cnt;
   logic        v;
   int          bad_count, samples_checked;
   int          c0, c1;
   logic [31:0] rows [15];
   reg_host_model host_i (.i_clk(clk), .i_rdata(rdata), .i_rdvalid(rdv), .o_wr(wr), .o_rd(rd),
      .o_addr(addr), .o_wdata(wdata));
   decoder_status_component_ctrl decoder_status_component_ctrl_i (.I_CLK(clk), .I_RSTN(rstn),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .O_REG_RDATA(rdata), .O_REG_RDVALID(rdv), .I_INTERLACE_DETECTED(st[7]),
      .I_HV_LOOPS_UNLOCKED(st[6]), .I_FIELD_RATE_ID(st[5]), .I_ALL_LOOPS_LOCKED(st[4]),
      .I_STRIPE_BURST_FOUR_LINE(st[3]), .I_STRIPE_BURST_ANY(st[2]),
      .I_COPY_PROTECT_SEEN(st[1]), .I_CAPTURE_READY(st[0]), .I_ADC_RAW(n[8:0]),
      .O_ADC_PORT_DATA(adc_o), .O_ADC_PORT_OE_N(oe_n), .O_ADC_CLOCK_EXTERNAL_SEL(ext),
      .O_ANALOG_OUT_SEL_HI(aout), .I_CLAMP_MODE_BIT(cm), .O_REF_PULL_EN(refp),
      .O_CLAMP_APPLY(clamp), .I_SOURCE_SWITCH_IN(sw), .O_GAIN_LOOP_RESET(grst),
      .O_CHAN3_GAIN(g3), .O_CHAN4_GAIN(g4), .I_PIXEL_MIX_IN(mix), .I_COMPOSITE_PIX(n),
      .I_COMPONENT_PIX(n + 16'h4000), .O_PIX(pix), .O_PIX_IS_COMPONENT(isc));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Held in reset so the time-zero falling edge cannot race the start value
   always @(negedge clk) if (rstn) n <= n + 16'h0001;
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      host_i.rd(a, q, v);
      chk("rdvalid", v, 1'b1);
      chk("rdata", q, e);
   endtask : rc
   // Sampled just after the edge, so n is the word the design took there
   task automatic pixchk(input logic [7:0] cfg, input logic [15:0] off, input logic c);
      host_i.wr(8'h29, cfg);
      repeat (40) @(posedge clk);
      #1;
      chk("pix", pix, n - 16'h0019 - off + (c ? 16'h4000 : 16'h0000));
      chk("is_component", isc, c);
      chk("adc_data", adc_o, n[8:0]);
   endtask : pixchk
   task automatic swchk(input logic [7:0] cfg, input logic [3:0] e);
      host_i.wr(8'h23, cfg);
      @(negedge clk) sw = ~sw;
      cnt = 4'h0;
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         #1;
         cnt = cnt + {3'h0, grst};
      end
      chk("gain_loop_reset", cnt, e);
   endtask : swchk
   // Falling edges from a rising mix pin to a component pick; only differences count
   task automatic mixdly(input logic [7:0] cfg, output int c);
      host_i.wr(8'h29, cfg);
      mix = 1'b0;
      repeat (40) @(negedge clk);
      mix = 1'b1;
      c = 0;
      while (isc !== 1'b1 && c < 60) begin
         @(negedge clk);
         c++;
      end
      if (c >= 60) begin
         chk("mix_wait", 16'(c), 16'h0000);
         report_and_stop();
      end
   endtask : mixdly
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      rstn = 1'b0;
      st = 8'h00;
      sw = 1'b0;
      mix = 1'b1;
      cm = 1'b1;
      n = 16'h0000;
      // Address, write data, status inputs, expected read
      rows = '{32'h1FFFFFEE, 32'h1F001101, 32'h1FFF8080, 32'h1F002020, 32'h1FFF0808,
         32'h1F000404, 32'h1FFF0202, 32'h1F004040, 32'h1FFF0100, 32'h1F001000,
         32'h23FF00F7, 32'h24A500A5, 32'h255A005A, 32'h29FF00FF, 32'h30FF0000};
      repeat (4) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      chk("oe_n", oe_n, 1'b1);
      chk("gain3", g3, 9'h000);
      $display("reset test done");
      foreach (rows[i]) begin
         st = rows[i][15:8];
         host_i.wr(rows[i][31:24], rows[i][23:16]);
         rc(rows[i][31:24], rows[i][7:0]);
      end
      $display("row test done");
      chk("aout", aout, 1'b1);
      host_i.wr(8'h23, 8'h71);
      repeat (2) @(negedge clk);
      chk("oe_n", oe_n, 1'b0);
      chk("ext_clk", ext, 1'b1);
      chk("ref", {refp, clamp}, 2'h2);
      chk("gain3", g3, 9'h1A5);
      chk("gain4", g4, 9'h05A);
      host_i.wr(8'h24, 8'h90);
      host_i.wr(8'h23, 8'h06);
      repeat (2) @(negedge clk);
      chk("oe_n", {oe_n, ext}, 2'h2);
      chk("ref", {refp, clamp}, 2'h1);
      chk("gain3", g3, 9'h090);
      chk("gain4", g4, 9'h15A);
      cm = 1'b0;
      repeat (2) @(negedge clk);
      chk("clamp", {refp, clamp}, 2'h0);
      cm = 1'b1;
      swchk(8'h00, 4'h0);
      swchk(8'h06, 4'h1);
      swchk(8'h44, 4'h1);
      $display("control test done");
      pixchk(8'h00, 16'h0000, 1'b0);
      pixchk(8'h40, 16'h0000, 1'b1);
      pixchk(8'h41, 16'h0004, 1'b1);
      pixchk(8'h44, 16'hFFF0, 1'b1);
      pixchk(8'h80, 16'h0000, 1'b1);
      pixchk(8'hC0, 16'h0000, 1'b0);
      $display("pixel test done");
      mixdly(8'h80, c0);
      mixdly(8'h90, c1);
      chk("mix_delay", 16'(c1 - c0), 16'h0001);
      mixdly(8'hA0, c1);
      chk("mix_delay", 16'(c1 - c0), 16'hFFFE);
      mixdly(8'hB0, c1);
      chk("mix_delay", 16'(c1 - c0), 16'hFFFF);
      $display("mix delay test done");
      @(negedge clk) rstn = 1'b0;
      #1;
      chk("oe_n", oe_n, 1'b1);
      @(negedge clk) rstn = 1'b1;
      rc(8'h29, 8'h00);
      $display("second reset test done");
      report_and_stop();
   end
endmodule : decoder_status_component_ctrl_tb

// ### pixel_delay_line.sv
// Tapped shift register with registered tap output
`timescale 1ns/100ps
module pixel_delay_line #(
   parameter int unsigned W     = 16,
   parameter int unsigned DEPTH = 36,
   parameter int unsigned SEL_W = 6
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic [W-1:0]     i_din,
   input  wire logic [SEL_W-1:0] i_sel,
   output logic      [W-1:0]     o_dout
);

   logic [W-1:0] taps_r [DEPTH];

   if (DEPTH < 2 || (2 ** SEL_W) < DEPTH) begin : g_bad_cfg
      $error("pixel_delay_line: DEPTH does not fit SEL_W");
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            taps_r[i] <= '0;
         end
      end else begin
         taps_r[0] <= i_din;
         for (int i = 1; i < DEPTH; i++) begin
            taps_r[i] <= taps_r[i-1];
         end
      end
   end

   // Out-of-range selects read the deepest tap rather than garbage
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dout <= '0;
      end else if (int'(i_sel) < DEPTH) begin
         o_dout <= taps_r[i_sel];
      end else begin
         o_dout <= taps_r[DEPTH-1];
      end
   end

endmodule : pixel_delay_line

// ### reg_host_model.sv
// Host side model issuing single-cycle register read and write strobes
`timescale 1ns/100ps
module reg_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rdvalid,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // Released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      v = i_rdvalid;
      d = i_rdata;
   endtask : rd
endmodule : reg_host_model
